// *** design/amssc_pkg.sv ***
/*
 * Shared constants of the converter mode sequencer: operating-mode codes,
 * reset values, the serial reset length and the sequencer state type.
 * Assumes nothing of its surroundings; imported by every design file.
 */
package amssc_pkg;

   // operating-mode codes as carried by the three mode bits
   localparam logic [2:0] MODE_IDLE   = 3'h0;
   localparam logic [2:0] MODE_CONT   = 3'h1;
   localparam logic [2:0] MODE_SINGLE = 3'h2;
   localparam logic [2:0] MODE_STBY   = 3'h3;
   localparam logic [2:0] MODE_ZS_ADC = 3'h4;
   localparam logic [2:0] MODE_RSVD   = 3'h5;
   localparam logic [2:0] MODE_ZS_CH  = 3'h6;
   localparam logic [2:0] MODE_FS_CH  = 3'h7;

   localparam logic [2:0] MODE_RESET_VAL = MODE_IDLE;
   localparam logic       RDY_N_RESET    = 1'h1;
   localparam logic       CS_N_RESET     = 1'h1;
   localparam logic       PIN_RESET      = 1'h0;

   // run of ones that resets the device from the serial input
   localparam logic [5:0] SRST_ONES      = 6'h20;

   localparam int unsigned NUM_CH_DEF    = 4;
   localparam int unsigned TIME_W_DEF    = 16;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_CONV,
      ST_CAL,
      ST_STBY
   } amssc_state_type;

endpackage

// *** design/amssc_sync.sv ***
/*
 * Pin input synchroniser: four flip-flops per bit, and the output only
 * follows once the second and third stages agree.
 * Assumes asynchronous inputs and a synchronous active-low reset.
 */
`timescale 1ns/1ps

module amssc_sync
   import amssc_pkg::*;
#(
   parameter int unsigned W         = 1,
   parameter logic [W-1:0] RST_VAL  = '0
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] pin,
   output logic      [W-1:0] level
);

   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   logic [W-1:0] lvl_q;
   logic [W-1:0] lvl_d;

   // the first stage feeds only the second, never any decision logic
   always_comb begin
      lvl_d = lvl_q;
      for (int i = 0; i < W; i++) begin
         if (s2_q[i] == s3_q[i]) begin
            lvl_d[i] = s3_q[i];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s1_q  <= RST_VAL;
         s2_q  <= RST_VAL;
         s3_q  <= RST_VAL;
         lvl_q <= RST_VAL;
      end else begin
         s1_q  <= pin;
         s2_q  <= s1_q;
         s3_q  <= s2_q;
         lvl_q <= lvl_d;
      end
   end

   assign level = lvl_q;

endmodule

// *** design/amssc_top.sv ***
/*
 * Operating-mode sequencer of a four-channel converter with the pin-level
 * side of its serial port: chip-select gating, ready output, two-wire
 * turnaround, the serial reset sequence and the reset pin.
 * Assumes: CLOCK is the master clock; the register protocol logic outside
 * presents mode writes, data-register reads and outgoing data bits as
 * same-clock signals; CS_N, SCLK and DIN arrive straight from pins.
 */
`timescale 1ns/1ps

// How it works
// - reset or power-up leaves mode bits zero and the sequencer idle.
// - calibrations and single conversions drop back to idle on their own.
// - continuous mode starts on the chosen channel, flags it, moves to next enabled.
// - continuous mode cycles enabled channels until a new mode or reset.
// - single conversion flags its channel, pulls ready low, clears mode, idles.
// - single conversion runs even when the channel is disabled.
// - standby powers down the converter; clock-out disable stays independent.
// - self zero-scale calibration sets every ready bit, ready low, then idle.
// - channel zero-scale calibration updates that channel, sets all ready bits, idles.
// - channel full-scale calibration updates that channel, sets all ready bits, idles.
// - with chip select high, serial clock and data are ignored, output released.
// - completion or new data is signalled by ready falling.
// - the ready output is always driven, never released.
// - the reset pin returns the whole device to defaults.
// - two-wire use: output driven only when sending; no continuous read.
// - a zero then thirty-two ones on the serial input resets the device.
// - power-on reset brings mode and registers to defaults.
// - a mode write clears status, raises ready, aborts and starts the new mode.
// - the write's low address bits pick the channel of the new operation.
// - reading a channel's data clears its ready bit; ready rises once no ready bit is left set.
module amssc_top
   import amssc_pkg::*;
#(
   parameter int unsigned NUM_CH = NUM_CH_DEF,
   parameter int unsigned TIME_W = TIME_W_DEF,
   localparam int unsigned CH_W  = $clog2(NUM_CH)
) (
   input  wire logic                     CLOCK,
   input  wire logic                     RESET_N,
   input  wire logic                     CS_N,
   input  wire logic                     SCLK,
   input  wire logic                     DIN,
   input  wire logic                     TWO_WIRE,
   input  wire logic                     SDO_REQ,
   input  wire logic                     SDO_BIT,
   input  wire logic                     MODE_WR,
   input  wire logic [2:0]               MODE_WR_CODE,
   input  wire logic [CH_W-1:0]          MODE_WR_CHAN,
   input  wire logic [NUM_CH-1:0]        CH_ENABLE,
   input  wire logic [NUM_CH*TIME_W-1:0] CONV_TIME,
   input  wire logic                     DATA_RD,
   input  wire logic [CH_W-1:0]          DATA_RD_CHAN,
   input  wire logic                     CONT_RD_REQ,
   input  wire logic                     MASTER_CLOCK_OUT_DISABLE,
   output logic                          OP_MODE_BIT_HIGH,
   output logic                          OP_MODE_BIT_MID,
   output logic                          OP_MODE_BIT_LOW,
   output logic [CH_W-1:0]               ACTIVE_CHAN,
   output logic [NUM_CH-1:0]             READY_BITS,
   output logic                          RDY_N,
   output logic                          CONV_DONE,
   output logic [CH_W-1:0]               DONE_CHAN,
   output logic                          ZS_SELF_CAL_DONE,
   output logic                          ZS_CH_CAL_DONE,
   output logic                          FS_CH_CAL_DONE,
   output logic                          POWER_DOWN,
   output logic                          MASTER_CLOCK_OUTPUT_PIN_OE,
   output logic                          CONT_RD_ACTIVE,
   output logic                          SDO_OUT,
   output logic                          SDO_OE,
   output logic                          SER_BIT_VALID,
   output logic                          SER_BIT,
   output logic                          SERIAL_RESET
);

   logic            cs_n_s;
   logic [1:0]      pin_s;
   logic            sclk_prev_q;
   logic            sclk_rise;
   logic            srst_q;
   logic            srst_d;
   logic            rst;
   logic [5:0]      ones_q;
   logic [5:0]      ones_d;
   logic            bitv_q;
   logic            bitv_d;
   logic            bit_q;
   logic            bit_d;
   logic            sdo_q;
   logic            sdo_d;
   logic            sdo_oe_q;
   logic            sdo_oe_d;
   logic            crd_q;
   logic            crd_d;

   amssc_state_type state_q;
   amssc_state_type state_d;
   logic [2:0]      mode_q;
   logic [2:0]      mode_d;
   logic [CH_W-1:0] chan_q;
   logic [CH_W-1:0] chan_d;
   logic [TIME_W-1:0] cnt_q;
   logic [TIME_W-1:0] cnt_d;
   logic [NUM_CH-1:0] rdy_q;
   logic [NUM_CH-1:0] rdy_d;
   logic            rdy_n_q;
   logic            rdy_n_d;
   logic            cdone_q;
   logic            cdone_d;
   logic [CH_W-1:0] dchan_q;
   logic [CH_W-1:0] dchan_d;
   logic            zsa_q;
   logic            zsa_d;
   logic            zsc_q;
   logic            zsc_d;
   logic            fsc_q;
   logic            fsc_d;
   logic            pd_q;
   logic            pd_d;
   logic            mco_q;
   logic            mco_d;

   // the reset pin and the serial reset both restart the sequencer and serial logic; only the pin resets the synchronisers and edge detector
   assign rst = !RESET_N || srst_q;

   amssc_sync #(
      .W       (1),
      .RST_VAL (CS_N_RESET)
   ) u_sync_cs (
      .clk   (CLOCK),
      .rst_n (RESET_N),
      .pin   (CS_N),
      .level (cs_n_s)
   );

   amssc_sync #(
      .W       (2),
      .RST_VAL ({PIN_RESET, PIN_RESET})
   ) u_sync_pins (
      .clk   (CLOCK),
      .rst_n (RESET_N),
      .pin   ({SCLK, DIN}),
      .level (pin_s)
   );

   assign sclk_rise = pin_s[1] && !sclk_prev_q;

   function automatic logic [TIME_W-1:0] load_time(input logic [CH_W-1:0] ch);
      logic [TIME_W-1:0] t;
      t = CONV_TIME[ch*TIME_W +: TIME_W];
      // a zero setting would never finish; run it as one cycle instead
      load_time = (t == '0) ? TIME_W'(1) : t;
   endfunction

   function automatic logic [CH_W-1:0] next_enabled(input logic [CH_W-1:0] ch);
      logic [CH_W-1:0] c;
      next_enabled = ch;
      for (int i = NUM_CH - 1; i >= 1; i--) begin
         c = CH_W'((int'(ch) + i) % NUM_CH);
         if (CH_ENABLE[c]) begin
            next_enabled = c;
         end
      end
   endfunction

   // serial side: gating, reset sequence and data output
   always_comb begin
      bitv_d   = 1'h0;
      bit_d    = bit_q;
      ones_d   = ones_q;
      srst_d   = 1'h0;
      if (!cs_n_s && sclk_rise) begin
         bitv_d = 1'h1;
         bit_d  = pin_s[0];
         if (!pin_s[0]) begin
            ones_d = '0;
         end else if (ones_q == SRST_ONES - 6'h01) begin
            ones_d = '0;
            srst_d = 1'h1;
         end else begin
            ones_d = ones_q + 6'h01;
         end
      end
      // the output is only driven while selected and sending, so a shared
      // two-wire line is free whenever the host must drive it
      sdo_oe_d = !cs_n_s && SDO_REQ;
      sdo_d    = SDO_BIT;
      crd_d    = CONT_RD_REQ && !TWO_WIRE;
   end

   always_ff @(posedge CLOCK) begin
      // the edge detector keeps its history through a serial reset: the clock
      // pin may still be high when that reset strikes, and a false edge would follow
      if (!RESET_N) begin
         srst_q      <= 1'h0;
         sclk_prev_q <= PIN_RESET;
      end else begin
         srst_q      <= srst_d;
         sclk_prev_q <= pin_s[1];
      end
      if (rst) begin
         ones_q      <= '0;
         bitv_q      <= 1'h0;
         bit_q       <= 1'h0;
         sdo_q       <= 1'h0;
         sdo_oe_q    <= 1'h0;
         crd_q       <= 1'h0;
      end else begin
         ones_q      <= ones_d;
         bitv_q      <= bitv_d;
         bit_q       <= bit_d;
         sdo_q       <= sdo_d;
         sdo_oe_q    <= sdo_oe_d;
         crd_q       <= crd_d;
      end
   end

   // mode sequencer
   always_comb begin
      state_d = state_q;
      mode_d  = mode_q;
      chan_d  = chan_q;
      cnt_d   = cnt_q;
      rdy_d   = rdy_q;
      cdone_d = 1'h0;
      dchan_d = dchan_q;
      zsa_d   = 1'h0;
      zsc_d   = 1'h0;
      fsc_d   = 1'h0;
      // a read clears first so that a completion in the same cycle wins
      if (DATA_RD) begin
         rdy_d[DATA_RD_CHAN] = 1'h0;
      end
      if (MODE_WR) begin
         rdy_d  = '0;
         mode_d = MODE_WR_CODE;
         chan_d = MODE_WR_CHAN;
         cnt_d  = load_time(MODE_WR_CHAN);
         unique case (MODE_WR_CODE)
            MODE_CONT, MODE_SINGLE: state_d = ST_CONV;
            MODE_STBY:              state_d = ST_STBY;
            MODE_ZS_ADC, MODE_ZS_CH, MODE_FS_CH: state_d = ST_CAL;
            default: begin
               // idle and the reserved code both leave the converter idle
               state_d = ST_IDLE;
               mode_d  = MODE_IDLE;
            end
         endcase
      end else begin
         unique case (state_q)
            ST_IDLE, ST_STBY: ;
            ST_CONV: begin
               if (cnt_q == TIME_W'(1)) begin
                  rdy_d[chan_q] = 1'h1;
                  cdone_d       = 1'h1;
                  dchan_d       = chan_q;
                  if (mode_q == MODE_CONT) begin
                     chan_d = next_enabled(chan_q);
                     cnt_d  = load_time(next_enabled(chan_q));
                  end else begin
                     state_d = ST_IDLE;
                     mode_d  = MODE_IDLE;
                  end
               end else begin
                  cnt_d = cnt_q - TIME_W'(1);
               end
            end
            ST_CAL: begin
               if (cnt_q == TIME_W'(1)) begin
                  rdy_d   = '1;
                  zsa_d   = (mode_q == MODE_ZS_ADC);
                  zsc_d   = (mode_q == MODE_ZS_CH);
                  fsc_d   = (mode_q == MODE_FS_CH);
                  dchan_d = chan_q;
                  state_d = ST_IDLE;
                  mode_d  = MODE_IDLE;
               end else begin
                  cnt_d = cnt_q - TIME_W'(1);
               end
            end
         endcase
      end
      // ready is a plain driven level: low while any channel holds news
      rdy_n_d = MODE_WR ? 1'h1 : !(|rdy_d);
      pd_d    = (state_d == ST_STBY);
      mco_d   = !MASTER_CLOCK_OUT_DISABLE;
   end

   always_ff @(posedge CLOCK) begin
      if (rst) begin
         state_q <= ST_IDLE;
         mode_q  <= MODE_RESET_VAL;
         chan_q  <= '0;
         cnt_q   <= '0;
         rdy_q   <= '0;
         rdy_n_q <= RDY_N_RESET;
         cdone_q <= 1'h0;
         dchan_q <= '0;
         zsa_q   <= 1'h0;
         zsc_q   <= 1'h0;
         fsc_q   <= 1'h0;
         pd_q    <= 1'h0;
         mco_q   <= 1'h0;
      end else begin
         state_q <= state_d;
         mode_q  <= mode_d;
         chan_q  <= chan_d;
         cnt_q   <= cnt_d;
         rdy_q   <= rdy_d;
         rdy_n_q <= rdy_n_d;
         cdone_q <= cdone_d;
         dchan_q <= dchan_d;
         zsa_q   <= zsa_d;
         zsc_q   <= zsc_d;
         fsc_q   <= fsc_d;
         pd_q    <= pd_d;
         mco_q   <= mco_d;
      end
   end

   assign OP_MODE_BIT_HIGH           = mode_q[2];
   assign OP_MODE_BIT_MID            = mode_q[1];
   assign OP_MODE_BIT_LOW            = mode_q[0];
   assign ACTIVE_CHAN                = chan_q;
   assign READY_BITS                 = rdy_q;
   assign RDY_N                      = rdy_n_q;
   assign CONV_DONE                  = cdone_q;
   assign DONE_CHAN                  = dchan_q;
   assign ZS_SELF_CAL_DONE           = zsa_q;
   assign ZS_CH_CAL_DONE             = zsc_q;
   assign FS_CH_CAL_DONE             = fsc_q;
   assign POWER_DOWN                 = pd_q;
   assign MASTER_CLOCK_OUTPUT_PIN_OE = mco_q;
   assign CONT_RD_ACTIVE             = crd_q;
   assign SDO_OUT                    = sdo_q;
   assign SDO_OE                     = sdo_oe_q;
   assign SER_BIT_VALID              = bitv_q;
   assign SER_BIT                    = bit_q;
   assign SERIAL_RESET               = srst_q;

   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (rst);

   idle_after_reset_a: assert property (
      $fell(rst) |-> mode_q == MODE_IDLE && state_q == ST_IDLE && !CONV_DONE)
      else $error("not idle after reset");
   single_done_idle_a: assert property (
      state_q == ST_CONV && mode_q == MODE_SINGLE && cnt_q == TIME_W'(1) && !MODE_WR
      |=> mode_q == MODE_IDLE && state_q == ST_IDLE && CONV_DONE && !RDY_N
          && READY_BITS[DONE_CHAN])
      else $error("single conversion did not finish into idle");
   cont_keeps_going_a: assert property (
      state_q == ST_CONV && mode_q == MODE_CONT && !MODE_WR
      |=> state_q == ST_CONV && mode_q == MODE_CONT)
      else $error("continuous conversion stopped by itself");
   single_disabled_ch_a: assert property (
      MODE_WR && MODE_WR_CODE == MODE_SINGLE && !CH_ENABLE[MODE_WR_CHAN]
      |=> state_q == ST_CONV && ACTIVE_CHAN == $past(MODE_WR_CHAN))
      else $error("single conversion refused a disabled channel");
   cal_all_ready_a: assert property (
      ZS_SELF_CAL_DONE || ZS_CH_CAL_DONE || FS_CH_CAL_DONE
      |-> READY_BITS == '1 && !RDY_N && mode_q == MODE_IDLE)
      else $error("calibration end without all ready bits");
   standby_power_a: assert property (
      mode_q == MODE_STBY |-> POWER_DOWN ##1
      MASTER_CLOCK_OUTPUT_PIN_OE == !$past(MASTER_CLOCK_OUT_DISABLE))
      else $error("standby or clock-out disable wrong");
   cs_gate_a: assert property (
      cs_n_s && $past(cs_n_s) |-> !SDO_OE ##1 !SER_BIT_VALID)
      else $error("serial port active while deselected");
   rdy_fall_cause_a: assert property (
      $fell(RDY_N) |-> |READY_BITS && $past(!MODE_WR))
      else $error("ready fell with no news");
   mode_write_a: assert property (
      MODE_WR |=> RDY_N && READY_BITS == '0
                  && mode_q == (($past(MODE_WR_CODE) == MODE_RSVD) ? MODE_IDLE
                                                                   : $past(MODE_WR_CODE)))
      else $error("mode write did not clear status");
   reserved_noop_a: assert property (
      MODE_WR && MODE_WR_CODE == MODE_RSVD
      |=> state_q == ST_IDLE && mode_q == MODE_IDLE ##1 READY_BITS == '0)
      else $error("reserved mode did something");
   serial_reset_a: assert property (
      !cs_n_s && sclk_rise && pin_s[0] && ones_q == SRST_ONES - 6'h01
      |=> SERIAL_RESET)
      else $error("serial reset missed");

   single_cov_c: cover property (MODE_WR && MODE_WR_CODE == MODE_SINGLE ##[1:300] CONV_DONE);
   cont_wrap_c: cover property (CONV_DONE && mode_q == MODE_CONT ##[1:600] CONV_DONE);
   cal_cov_c: cover property (FS_CH_CAL_DONE || ZS_CH_CAL_DONE || ZS_SELF_CAL_DONE);
   srst_cov_c: cover property (SERIAL_RESET);

endmodule

// *** test/amssc_host_model.sv ***
/*
 * Host serial port model: drives chip select, serial clock and data in.
 * Assumes the bench calls send() and that the device samples data at
 * the serial clock's rising edge; the clock rests low between frames.
 */
`timescale 1ns/1ps

module amssc_host_model (
   output logic cs_n,
   output logic sclk,
   output logic din
);
   initial begin
      cs_n = 1'h1;
      sclk = 1'h0;
      din  = 1'h1;
   end

   // clock toggles only inside a frame, so no stray write edges
   task automatic send(input int n, input logic [31:0] v, input bit sel);
      cs_n = !sel;
      #800;
      for (int i = n - 1; i >= 0; i--) begin
         din = v[i];
         #400;
         sclk = 1'h1;
         #400;
         sclk = 1'h0;
      end
      #800;
      cs_n = 1'h1;
      // released line: show the inverse so a stale level cannot pass
      din = !din;
   endtask
endmodule

// *** test/amssc_top_tb.sv ***
/*
 * Self-checking bench of the mode sequencer and its serial pin side.
 * Assumes the host model drives the serial pins and the bench drives the
 * same-clock register-side inputs at the rising edge.
 */
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin bad_count++; \
   $display("[FAIL] t=%0t got %0h exp %0h", $time, (a), (e)); end end

module amssc_top_tb;
   import amssc_pkg::*;
   logic clk = 0, rst_n = 0, two_wire = 0, sdo_req = 0, sdo_bit = 0, mode_wr = 0;
   logic data_rd = 0, cont_rd_req = 0, clk_dis = 0;
   logic [2:0] code = 3'h0;
   logic [1:0] chan = 2'h0, rd_chan = 2'h0, act_ch, done_ch;
   logic [3:0] ch_en = 4'h1, rdy_bits;
   logic [63:0] conv_time = 64'h0004_0005_0003_0003;
   logic cs_n, sclk, din, md_h, md_m, md_l, rdy_n, conv_done, zs_self, zs_ch, fs_ch;
   logic pwr_dn, mclk_oe, cont_rd_act, sdo_out, sdo_oe, ser_valid, ser_bit, ser_rst;
   int bad_count = 0, total_checks = 0, bits_seen = 0, resets_seen = 0, n;

   always #50 clk = ~clk;

   amssc_host_model host_u (.cs_n(cs_n), .sclk(sclk), .din(din));

   amssc_top dut_u (.CLOCK(clk), .RESET_N(rst_n), .CS_N(cs_n), .SCLK(sclk), .DIN(din),
      .TWO_WIRE(two_wire), .SDO_REQ(sdo_req), .SDO_BIT(sdo_bit), .MODE_WR(mode_wr),
      .MODE_WR_CODE(code), .MODE_WR_CHAN(chan), .CH_ENABLE(ch_en), .CONV_TIME(conv_time),
      .DATA_RD(data_rd), .DATA_RD_CHAN(rd_chan), .CONT_RD_REQ(cont_rd_req),
      .MASTER_CLOCK_OUT_DISABLE(clk_dis), .OP_MODE_BIT_HIGH(md_h), .OP_MODE_BIT_MID(md_m),
      .OP_MODE_BIT_LOW(md_l), .ACTIVE_CHAN(act_ch), .READY_BITS(rdy_bits), .RDY_N(rdy_n),
      .CONV_DONE(conv_done), .DONE_CHAN(done_ch), .ZS_SELF_CAL_DONE(zs_self),
      .ZS_CH_CAL_DONE(zs_ch), .FS_CH_CAL_DONE(fs_ch), .POWER_DOWN(pwr_dn),
      .MASTER_CLOCK_OUTPUT_PIN_OE(mclk_oe), .CONT_RD_ACTIVE(cont_rd_act),
      .SDO_OUT(sdo_out), .SDO_OE(sdo_oe), .SER_BIT_VALID(ser_valid), .SER_BIT(ser_bit),
      .SERIAL_RESET(ser_rst));

   always @(posedge clk) begin
      if (ser_valid === 1'b1) bits_seen++;
      if (ser_rst === 1'b1) resets_seen++;
   end

   task automatic tick(int k = 1);
      repeat (k) @(posedge clk);
      #1;
   endtask

   // stands for a communications write followed by the mode register write
   task automatic write_mode(logic [2:0] c, logic [1:0] ch);
      @(posedge clk);
      mode_wr <= 1'h1;
      code    <= c;
      chan    <= ch;
      @(posedge clk);
      mode_wr <= 1'h0;
      #1;
   endtask

   task automatic read_data(logic [1:0] ch);
      @(posedge clk);
      data_rd <= 1'h1;
      rd_chan <= ch;
      @(posedge clk);
      data_rd <= 1'h0;
      tick(1);
   endtask

   // edges from the taking edge until a completion strobe shows
   task automatic wait_done(output int k);
      k = 0;
      do begin
         tick(1);
         k++;
      end while ((conv_done | zs_self | zs_ch | fs_ch) !== 1'b1 && k < 200);
   endtask

   task automatic results;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial begin
      #1_000_000;
      bad_count++;
      $display("[FAIL] t=%0t watchdog expired", $time);
      results();
   end

   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'h1;
      tick(1);
      `CHK({md_h, md_m, md_l, rdy_n, rdy_bits, pwr_dn, sdo_oe}, 10'h040)
      // single conversion on a disabled channel, then read it back
      write_mode(MODE_SINGLE, 2'h1);
      wait_done(n);
      `CHK(n, 3)
      `CHK({md_h, md_m, md_l, rdy_n, rdy_bits, done_ch}, 10'h009)
      read_data(2'h1);
      `CHK({rdy_bits, rdy_n}, 5'h01)
      $display("test single done");
      // continuous over channels 0 and 2, started on 0
      @(posedge clk);
      ch_en <= 4'h5;
      write_mode(MODE_CONT, 2'h0);
      tick(1);
      `CHK({act_ch, md_h, md_m, md_l}, 5'h01)
      // one edge of the first conversion passed during the channel check
      wait_done(n);
      `CHK({n[3:0], done_ch}, 6'h08)
      wait_done(n);
      `CHK({n[3:0], done_ch}, 6'h16)
      wait_done(n);
      `CHK({n[3:0], done_ch, rdy_bits, rdy_n}, 11'h18A)
      write_mode(MODE_IDLE, 2'h0);
      tick(10);
      `CHK({md_h, md_m, md_l, rdy_n, rdy_bits}, 8'h10)
      $display("test continuous done");
      for (int i = 0; i < 3; i++) begin
         write_mode(i == 0 ? MODE_ZS_ADC : (i == 1 ? MODE_ZS_CH : MODE_FS_CH), 2'h2);
         wait_done(n);
         `CHK(n, 5)
         `CHK({zs_self, zs_ch, fs_ch}, 3'h4 >> i)
         `CHK({md_h, md_m, md_l, rdy_n, rdy_bits}, 8'h0F)
      end
      $display("test calibration done");
      write_mode(MODE_RSVD, 2'h1);
      tick(10);
      `CHK({md_h, md_m, md_l, rdy_n, rdy_bits, pwr_dn}, 9'h020)
      write_mode(MODE_STBY, 2'h0);
      tick(1);
      `CHK({md_h, md_m, md_l, pwr_dn, mclk_oe}, 5'h0F)
      clk_dis <= 1'h1;
      tick(2);
      `CHK({pwr_dn, mclk_oe}, 2'h2)
      $display("test standby done");
      // serial side, still in standby
      two_wire <= 1'h1;
      cont_rd_req <= 1'h1;
      sdo_req <= 1'h1;
      sdo_bit <= 1'h1;
      tick(2);
      `CHK({cont_rd_act, sdo_oe}, 2'h0)
      fork
         host_u.send(8, 32'h0000_0000, 1'b1);
         begin
            #2000;
            `CHK({sdo_oe, sdo_out}, 2'h3)
         end
      join
      two_wire <= 1'h0;
      host_u.send(32, 32'hFFFF_FFFE, 1'b1);
      host_u.send(31, 32'h7FFF_FFFF, 1'b1);
      host_u.send(8, 32'h0000_00FF, 1'b0);
      tick(5);
      `CHK({ser_bit, cont_rd_act, resets_seen[3:0], md_m, md_l, pwr_dn}, 9'h187)
      host_u.send(1, 32'h0000_0001, 1'b1);
      tick(5);
      `CHK({bits_seen[7:0], resets_seen[3:0]}, 12'h481)
      `CHK({md_h, md_m, md_l, pwr_dn, rdy_n}, 5'h01)
      $display("test serial done");
      write_mode(MODE_CONT, 2'h1);
      tick(2);
      rst_n <= 1'h0;
      tick(5);
      rst_n <= 1'h1;
      tick(1);
      `CHK({md_h, md_m, md_l, rdy_n, rdy_bits}, 8'h10)
      $display("test reset pin done");
      results();
   end
endmodule
